// [rtl/sacc_pkg.sv]
// sacc_pkg: constants and carrier types for the successive-approximation
// converter control block.
// assumes one 125 MHz system clock; f_x is modelled by a clock enable.
package sacc_pkg;
    // converter resolution and channel count
    localparam int DATA_W = 8;
    localparam int CHAN_N = 4;
    localparam int CHAN_W = 2;
    // data register value after reset and after standby stop
    localparam logic [7:0] DATA_RESET = 8'h00;
    // timing in f_x periods
    localparam int SAMPLE_FX = 14;
    localparam int REPEAT_FX = 48;
    localparam int SAMPLES_PER_CONV = 8;
    // one instruction cycle is 16 f_x periods
    localparam int INSTR_FX = 16;
    localparam int SINGLE_INSTRS = 3;
    localparam int SINGLE_FX = INSTR_FX * SINGLE_INSTRS;
    // f_x divider: system clock periods per f_x period
    localparam int FX_DIV = 1;
    // counter width for f_x counts
    localparam int FXCNT_W = 8;

    typedef enum {
        SACC_IDLE,
        SACC_SAMPLE,
        SACC_SETTLE,
        SACC_SINGLE
    } sacc_state_t;

    // software-side control strobes and levels
    typedef struct packed {
        logic mode_single;
        logic start_wr;
        logic [1:0] chan;
    } sacc_ctrl_t;

    // flags the block reports
    typedef struct packed {
        logic done;
        logic cmp;
        logic busy;
    } sacc_stat_t;
endpackage : sacc_pkg

// [rtl/sacc_fx_div.sv]
// sacc_fx_div: divides the system clock down to a one-cycle f_x enable.
// assumes an asynchronous active-low reset from the top module.
`timescale 1ns/1ps
`default_nettype none
module sacc_fx_div #(
    parameter int DIV = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // enable out
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;

    if (DIV < 1) begin : g_bad_div
        $error("sacc_fx_div: DIV must be at least 1");
    end

    always_comb begin
        if (cnt == CW'(DIV - 1)) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick = (cnt == CW'(DIV - 1));
endmodule : sacc_fx_div
`default_nettype wire

// [rtl/sacc_core.sv]
// sacc_core: control for an 8-bit successive-approximation converter with
// four analog inputs, successive and single-compare modes.
// assumes the comparator and D/A are analog; comp_in is their digital result.
// Notes on behaviour
// - Mode select 0 runs successive conversion, 1 runs single comparison.
// - Successive mode decides all eight bits, most significant first.
// - Comparator gives 1 when input is above the D/A level and feeds data or flag.
// - Single mode drives the data register to the D/A and compares once.
// - In single mode a start write gives a compare result three instruction cycles later.
// - In single mode a data register write starts a comparison like the start flag.
// - The compare result flag clears on reset and on a data register write in single mode, except a write in the cycle a compare completes.
// - Data register writes are ignored while mode select is 0.
// - In successive mode the reference draws current from start until done.
// - In single mode the reference draws current from start until the flag is written.
// - Standby halt does not stop an operation in progress.
// - Standby stop aborts, clears the data register to 00H and cuts reference current.
// - A conversion is eight samples of 14 f_x each, repeating every 48 f_x.
// - Four channels are served, one selected channel converted at a time.
// - The data register supports peripheral read and write accesses.
// - The reference pin is a reference input when any analog select bit is 1, reading 0.
`timescale 1ns/1ps
`default_nettype none
module sacc_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // software control
    input wire sacc_pkg::sacc_ctrl_t ctrl,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic data_rd,
    input wire logic halt_mode,
    input wire logic stop_mode,
    // analog front end
    input wire logic comp_in,
    output logic [7:0] dac_code,
    output logic [1:0] chan_sel,
    output logic sample_en,
    output logic ref_on,
    // reference pin sharing
    input wire logic [3:0] analog_pin_select_bits,
    input wire logic ref_pin_level,
    output logic ref_pin_is_ref,
    output logic ref_pin_read,
    // register read side
    output logic [7:0] conversion_data_register,
    output logic [7:0] rdata,
    output sacc_pkg::sacc_stat_t stat
);
    logic rst_s1, rst_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    logic fx;
    sacc_fx_div #(.DIV(sacc_pkg::FX_DIV)) u_div (
        .clk(clk),
        .rst_n(rst_s2),
        .tick(fx)
    );

    sacc_pkg::sacc_state_t state, next_state;
    logic [7:0] data, next_data;
    logic [7:0] trial, next_trial;
    logic [2:0] bitn, next_bitn;
    logic [sacc_pkg::FXCNT_W-1:0] cnt, next_cnt;
    logic [1:0] chan, next_chan;
    logic done, next_done;
    logic cmp, next_cmp;
    logic [7:0] rd_q, next_rd_q;

    // write accepted only in single mode
    logic wr_ok;
    assign wr_ok = data_wr && ctrl.mode_single;

    always_comb begin
        next_state = state;
        next_data = data;
        next_trial = trial;
        next_bitn = bitn;
        next_cnt = cnt;
        next_chan = chan;
        next_done = done;
        next_cmp = cmp;
        next_rd_q = rd_q;
        if (data_rd) begin
            next_rd_q = data;
        end
        if (wr_ok) begin
            next_data = data_wdata;
        end
        if (wr_ok) begin
            next_cmp = 1'b0;
        end
        case (state)
            sacc_pkg::SACC_IDLE: begin
                if (!ctrl.mode_single && ctrl.start_wr) begin
                    next_state = sacc_pkg::SACC_SAMPLE;
                    next_chan = ctrl.chan;
                    next_done = 1'b0;
                    next_data = sacc_pkg::DATA_RESET;
                    next_trial = 8'h80;
                    next_bitn = 3'd7;
                    next_cnt = '0;
                end else if (ctrl.mode_single && (ctrl.start_wr || wr_ok)) begin
                    next_state = sacc_pkg::SACC_SINGLE;
                    next_chan = ctrl.chan;
                    next_cnt = '0;
                end
            end
            sacc_pkg::SACC_SAMPLE: begin
                if (fx) begin
                    if (cnt == sacc_pkg::FXCNT_W'(sacc_pkg::SAMPLE_FX - 1)) begin
                        next_state = sacc_pkg::SACC_SETTLE;
                        // keep bit when input above trial
                        next_data = comp_in ? trial : (trial & ~(8'h01 << bitn));
                    end
                    next_cnt = cnt + sacc_pkg::FXCNT_W'(1);
                end
            end
            sacc_pkg::SACC_SETTLE: begin
                if (fx) begin
                    next_cnt = cnt + sacc_pkg::FXCNT_W'(1);
                    if (cnt == sacc_pkg::FXCNT_W'(sacc_pkg::REPEAT_FX - 1)) begin
                        next_cnt = '0;
                        if (bitn == 3'd0) begin
                            next_state = sacc_pkg::SACC_IDLE;
                            next_done = 1'b1;
                        end else begin
                            next_bitn = bitn - 3'd1;
                            next_trial = data | (8'h01 << (bitn - 3'd1));
                            next_state = sacc_pkg::SACC_SAMPLE;
                        end
                    end
                end
            end
            sacc_pkg::SACC_SINGLE: begin
                if (fx) begin
                    next_cnt = cnt + sacc_pkg::FXCNT_W'(1);
                    if (cnt == sacc_pkg::FXCNT_W'(sacc_pkg::SINGLE_FX - 1)) begin
                        next_cmp = comp_in;
                        next_state = sacc_pkg::SACC_IDLE;
                    end
                end
            end
            default: begin
                next_state = sacc_pkg::SACC_IDLE;
            end
        endcase
        if (stop_mode) begin
            next_state = sacc_pkg::SACC_IDLE;
            next_data = sacc_pkg::DATA_RESET;
            next_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            state <= sacc_pkg::SACC_IDLE;
            data <= sacc_pkg::DATA_RESET;
            trial <= 8'h00;
            bitn <= 3'd0;
            cnt <= '0;
            chan <= 2'd0;
            done <= 1'b0;
            cmp <= 1'b0;
            rd_q <= 8'h00;
        end else begin
            state <= next_state;
            data <= next_data;
            trial <= next_trial;
            bitn <= next_bitn;
            cnt <= next_cnt;
            chan <= next_chan;
            done <= next_done;
            cmp <= next_cmp;
            rd_q <= next_rd_q;
        end
    end

    logic busy;
    assign busy = (state != sacc_pkg::SACC_IDLE);
    // single mode drives data register to the D/A
    assign dac_code = (state == sacc_pkg::SACC_SAMPLE || state == sacc_pkg::SACC_SETTLE) ? trial : data;
    assign chan_sel = chan;
    assign sample_en = (state == sacc_pkg::SACC_SAMPLE) || (state == sacc_pkg::SACC_SINGLE);
    assign ref_on = busy;
    assign ref_pin_is_ref = |analog_pin_select_bits;
    assign ref_pin_read = ref_pin_is_ref ? 1'b0 : ref_pin_level;
    assign conversion_data_register = data;
    assign rdata = rd_q;
    assign stat = '{done: done, cmp: cmp, busy: busy};

    property p_wr_ignored;
        @(posedge clk) disable iff (!rst_s2)
        (data_wr && !ctrl.mode_single && !stop_mode && state == sacc_pkg::SACC_IDLE && !ctrl.start_wr)
            |=> $stable(data);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("data changed on ignored write");

    property p_cmp_clear;
        @(posedge clk) disable iff (!rst_s2)
        (wr_ok && state == sacc_pkg::SACC_IDLE) |=> !cmp;
    endproperty
    a_cmp_clear: assert property (p_cmp_clear) else $error("compare flag not cleared");

    // stop clears data and goes idle
    property p_stop;
        @(posedge clk) disable iff (!rst_s2)
        stop_mode |=> (data == 8'h00) && !ref_on;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");

    // reference cut as the done flag sets
    property p_ref;
        @(posedge clk) disable iff (!rst_s2)
        $rose(done) |-> !ref_on && $past(ref_on);
    endproperty
    a_ref: assert property (p_ref) else $error("reference current mismatch");

    property p_chan;
        @(posedge clk) disable iff (!rst_s2)
        (busy && $past(busy)) |-> $stable(chan_sel);
    endproperty
    a_chan: assert property (p_chan) else $error("channel moved during operation");

    // reference pin reads zero when shared
    property p_refpin;
        @(posedge clk) disable iff (!rst_s2)
        (|analog_pin_select_bits) |-> (ref_pin_read == 1'b0) && ref_pin_is_ref;
    endproperty
    a_refpin: assert property (p_refpin) else $error("reference pin read not zero");

    sequence s_single_go;
        state == sacc_pkg::SACC_IDLE && ctrl.mode_single && ctrl.start_wr && !stop_mode;
    endsequence
    property p_single;
        @(posedge clk) disable iff (!rst_s2)
        s_single_go |=> state == sacc_pkg::SACC_SINGLE;
    endproperty
    a_single: assert property (p_single) else $error("single mode not entered");

    // data write in single mode loads and starts a compare
    property p_wr_start;
        @(posedge clk) disable iff (!rst_s2)
        (state == sacc_pkg::SACC_IDLE && wr_ok && !stop_mode)
            |=> state == sacc_pkg::SACC_SINGLE && data == $past(data_wdata);
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("data write did not start compare");

    // successive start enters sampling with MSB trial
    property p_succ;
        @(posedge clk) disable iff (!rst_s2)
        (state == sacc_pkg::SACC_IDLE && !ctrl.mode_single && ctrl.start_wr && !stop_mode)
            |=> state == sacc_pkg::SACC_SAMPLE && trial == 8'h80 && !done;
    endproperty
    a_succ: assert property (p_succ) else $error("successive start wrong");
endmodule : sacc_core
`default_nettype wire

// [tb/sacc_analog_model.sv]
// sacc_analog_model: analog sources and comparator beside the converter.
// assumes one level byte per channel, driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model (
    // converter side
    input wire logic [1:0] chan_sel,
    input wire logic [7:0] dac_code,
    // input levels, one byte per channel
    input wire logic [31:0] levels,
    // comparator out
    output logic comp_in
);
    assign comp_in = levels[chan_sel*8 +: 8] > dac_code;
endmodule : sacc_analog_model
`default_nettype wire

// [tb/tb_top.sv]
// tb_top: self-checking bench for the converter control block.
// assumes f_x equals the system clock, as the package sets it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, (a), (b)); end end
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sacc_pkg::sacc_ctrl_t ctrl = '0;
    logic data_wr = 1'b0;
    logic [7:0] data_wdata = 8'h00;
    logic data_rd = 1'b0;
    logic halt_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic [3:0] pin_sel = 4'h0;
    logic ref_pin_level = 1'b0;
    logic [31:0] levels = 32'h00000000;
    logic comp_in, sample_en, ref_on, ref_pin_is_ref, ref_pin_read;
    logic [7:0] dac_code, data_reg, rdata;
    logic [1:0] chan_sel;
    sacc_pkg::sacc_stat_t stat;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    logic [7:0] v;
    localparam int SUCC_LEN = sacc_pkg::SAMPLES_PER_CONV * sacc_pkg::REPEAT_FX;

    always #4 clk = ~clk;

    sacc_core u_sacc_core (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .data_wr(data_wr),
        .data_wdata(data_wdata), .data_rd(data_rd), .halt_mode(halt_mode), .stop_mode(stop_mode),
        .comp_in(comp_in), .dac_code(dac_code), .chan_sel(chan_sel), .sample_en(sample_en),
        .ref_on(ref_on), .analog_pin_select_bits(pin_sel), .ref_pin_level(ref_pin_level),
        .ref_pin_is_ref(ref_pin_is_ref), .ref_pin_read(ref_pin_read),
        .conversion_data_register(data_reg), .rdata(rdata), .stat(stat));
    sacc_analog_model u_sacc_analog_model (.chan_sel(chan_sel), .dac_code(dac_code),
        .levels(levels), .comp_in(comp_in));

    // reference successive approximation, most significant bit first
    function automatic logic [7:0] sar(input logic [7:0] lvl);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 7; b >= 0; b--) begin
            if (lvl > (r | (8'h01 << b))) r = r | (8'h01 << b);
        end
        return r;
    endfunction : sar

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic start(input logic [1:0] ch);
        ctrl.chan = ch;
        ctrl.start_wr = 1'b1;
        tick();
        ctrl.start_wr = 1'b0;
    endtask : start

    // software side: data register write, accepted only in single mode
    task automatic wr(input logic [7:0] d, input logic [1:0] ch);
        ctrl.chan = ch;
        data_wdata = d;
        data_wr = 1'b1;
        tick();
        data_wr = 1'b0;
        data_wdata = ~d;
    endtask : wr

    task automatic rd();
        data_rd = 1'b1;
        tick();
        data_rd = 1'b0;
    endtask : rd

    // waits for idle while disturbing the channel input
    task automatic wait_idle(input logic [1:0] ch, input int len, output int cnt);
        logic exp_busy;
        logic exp_smp;
        cnt = 0;
        exp_busy = 1'b0;
        exp_smp = 1'b0;
        do begin
            ctrl.chan = 2'($urandom);
            tick();
            cnt++;
            exp_busy = (cnt < len);
            exp_smp = exp_busy && (ctrl.mode_single || ((cnt % sacc_pkg::REPEAT_FX) < sacc_pkg::SAMPLE_FX));
            if (exp_busy) begin
                `CHK(chan_sel, ch)
            end
            `CHK(stat.busy, exp_busy)
            `CHK(ref_on, exp_busy)
            `CHK(sample_en, exp_smp)
        end while (stat.busy !== 1'b0 && cnt < 1000);
        ctrl.chan = ch;
    endtask : wait_idle

    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end

    initial begin
        n = $urandom(32'h3744);
        levels = {8'hff, 8'($urandom), 8'($urandom), 8'h00};
        repeat (16) tick();
        rst_n = 1'b1;
        repeat (3) tick();
        `CHK(data_reg, sacc_pkg::DATA_RESET)
        `CHK(stat.cmp, 1'b0)
        `CHK(ref_on, 1'b0)
        `CHK(sample_en, 1'b0)
        // successive conversions over every channel, halt held during one
        for (int i = 0; i < sacc_pkg::CHAN_N; i++) begin
            halt_mode = (i == 1);
            start(2'(i));
            wait_idle(2'(i), SUCC_LEN, n);
            halt_mode = 1'b0;
            `CHK(n, SUCC_LEN)
            `CHK(stat.done, 1'b1)
            rd();
            `CHK(rdata, sar(levels[i*8 +: 8]))
        end
        v = data_reg;
        wr(~v, 2'd0);
        tick();
        `CHK(data_reg, v)
        `CHK(stat.busy, 1'b0)
        // single compares, by data write and by start flag
        ctrl.mode_single = 1'b1;
        tick();
        for (int k = 0; k < 8; k++) begin
            if (k % 2 == 0) begin
                v = (k == 0) ? levels[15:8] : 8'($urandom);
                wr(v, 2'(k % 4));
                `CHK(stat.cmp, 1'b0)
            end else begin
                start(2'(k % 4));
            end
            wait_idle(2'(k % 4), sacc_pkg::SINGLE_FX, n);
            `CHK(n, sacc_pkg::SINGLE_FX)
            `CHK(stat.cmp, (levels[(k % 4)*8 +: 8] > v))
            `CHK(dac_code, v)
            `CHK(data_reg, v)
        end
        // stop in mid-compare
        wr(8'h5a, 2'd1);
        repeat (10) tick();
        stop_mode = 1'b1;
        tick();
        tick();
        `CHK(stat.busy, 1'b0)
        `CHK(ref_on, 1'b0)
        `CHK(sample_en, 1'b0)
        `CHK(data_reg, 8'h00)
        stop_mode = 1'b0;
        repeat (60) tick();
        `CHK(stat.busy, 1'b0)
        `CHK(ref_on, 1'b0)
        // shared reference pin
        for (int k = 0; k < 8; k++) begin
            pin_sel = (k == 0) ? 4'h0 : 4'($urandom);
            ref_pin_level = (k < 2) ? 1'b1 : 1'($urandom);
            tick();
            `CHK(ref_pin_is_ref, |pin_sel)
            `CHK(ref_pin_read, ((|pin_sel) ? 1'b0 : ref_pin_level))
        end
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
